// ---- design/dts_defines.svh ----
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

// ==============================================================
// Register indices (word addresses, byte address = 4 * index)
`define DTS_CH1_IDX 32'hFFFFF812
`define DTS_CH2_IDX 32'hFFFFF814
`define DTS_ISTAT_IDX 32'hFFFFF820
`define DTS_IMASK_IDX 32'hFFFFF821

// ==============================================================
// Trigger register fields
`define DTS_PEND_BIT 7
`define DTS_OVF_BIT 6
`define DTS_FIX1_BIT 5
`define DTS_SRC_MSB 2
`define DTS_SRC_LSB 0

// ==============================================================
// Interrupt status / mask layout
`define DTS_IS_TRIG_LSB 0
`define DTS_IS_OVF_LSB 2

// ==============================================================
// Reset values
`define DTS_TSEL_RST 8'h00
`define DTS_IREG_RST 4'h0

`endif

// ---- design/dts_pkg.sv ----
package dts_pkg;

	// ==============================================================
	// Bus answer state
	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} dts_bus_e;

	// ==============================================================
	// Register selected by an address
	typedef enum logic [2:0] {
		REG_NONE,
		REG_CH1,
		REG_CH2,
		REG_ISTAT,
		REG_IMASK
	} dts_reg_e;

	// ==============================================================
	// Peripheral interrupt request pulses
	typedef struct packed {
		logic serial_port_a;
		logic serial_port_b;
		logic serial_port_c;
		logic uart_a_rx;
		logic uart_b_rx;
		logic uart_a_tx;
		logic uart_b_tx;
		logic adc_end;
		logic general_timer_a_cc2;
		logic general_timer_a_cc3;
		logic general_timer_b_cc3;
		logic dedicated_timer_a_match;
	} dts_irq_s;

	// ==============================================================
	// Whole state of the top module
	typedef struct packed {
		dts_bus_e bus;
		logic waitreq;
		logic [31:0] rdata;
		logic [1:0][7:0] tsel;
		logic [3:0] istat;
		logic [3:0] imask;
		logic irq;
	} dts_state_s;

endpackage

// ---- design/dts_trig_mux.sv ----
`timescale 1ns/1ps

module dts_trig_mux
	import dts_pkg::*;
(
	input wire logic [7:0] src_i,    // Candidate requests, index = source code
	input wire logic [2:0] sel_i,    // Source field of the channel
	input wire logic standby_i,      // Chip in idle, watch or stop mode
	output logic trig_o              // Start trigger for the channel
);

	// ==============================================================
	// Selection
	always_comb begin
		trig_o = src_i[sel_i] & ~standby_i;
	end

endmodule // dts_trig_mux

// ---- design/dts_top.sv ----
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "dts_defines.svh"

module dts_top
	import dts_pkg::*;
(
	input wire logic clk_i,                   // 100 MHz clock
	input wire logic reset_i,                 // Synchronous reset, active high
	input wire logic [31:0] avs_address_i,    // Word address
	input wire logic avs_read_i,              // Read request
	input wire logic avs_write_i,             // Write request
	input wire logic [31:0] avs_writedata_i,  // Write data
	input wire logic [3:0] avs_byteenable_i,  // Byte lanes
	output logic [31:0] avs_readdata_o,       // Read data
	output logic avs_waitrequest_o,           // Stall until answer
	input wire dts_irq_s irq_src_i,           // Peripheral request pulses
	input wire logic standby_i,               // Chip in standby mode
	input wire logic [1:0] service_i,         // Sequencer took pending transfer
	output logic [1:0] dma_req_o,             // Pending transfer per channel
	output logic irq_o                        // Level interrupt
);

	// ==============================================================
	// Address decode, shared by read mux and write path
	function automatic dts_reg_e reg_decode(input logic [31:0] addr);
		dts_reg_e r;
		r = REG_NONE;
		case (addr)
			`DTS_CH1_IDX: r = REG_CH1;
			`DTS_CH2_IDX: r = REG_CH2;
			`DTS_ISTAT_IDX: r = REG_ISTAT;
			`DTS_IMASK_IDX: r = REG_IMASK;
			default: r = REG_NONE;
		endcase
		return r;
	endfunction

	dts_state_s s_r;
	dts_state_s s_nxt;
	dts_reg_e hit;
	logic [1:0][7:0] src_vec;
	logic [1:0] trig;
	logic wr_ok;

	assign hit = reg_decode(avs_address_i);
	// Writes land only on the answering edge, so the master sees them once
	assign wr_ok = (s_r.bus == BUS_ACK) && avs_write_i && avs_byteenable_i[0];

	// ==============================================================
	// Source tables, bit position = source code
	always_comb begin
		src_vec[0] = {irq_src_i.dedicated_timer_a_match, irq_src_i.general_timer_a_cc2,
			irq_src_i.adc_end, irq_src_i.uart_b_rx, irq_src_i.uart_a_rx,
			irq_src_i.serial_port_c, irq_src_i.serial_port_b, irq_src_i.serial_port_a};
		src_vec[1] = {irq_src_i.general_timer_b_cc3, irq_src_i.general_timer_a_cc3,
			irq_src_i.adc_end, irq_src_i.uart_b_tx, irq_src_i.uart_a_tx,
			irq_src_i.serial_port_c, irq_src_i.serial_port_b, irq_src_i.serial_port_a};
	end

	genvar gc;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_ch
			dts_trig_mux u_mux (
				.src_i(src_vec[gc]),
				.sel_i(s_r.tsel[gc][`DTS_SRC_MSB:`DTS_SRC_LSB]),
				.standby_i(standby_i),
				.trig_o(trig[gc])
			);
		end
	endgenerate

	// ==============================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		case (s_r.bus)
			BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					s_nxt.bus = BUS_ACK;
					s_nxt.waitreq = 1'b0;
					s_nxt.rdata = 32'h0000_0000;
					case (hit)
						REG_CH1: s_nxt.rdata[7:0] = s_r.tsel[0];
						REG_CH2: s_nxt.rdata[7:0] = s_r.tsel[1];
						REG_ISTAT: s_nxt.rdata[3:0] = s_r.istat;
						REG_IMASK: s_nxt.rdata[3:0] = s_r.imask;
						default: s_nxt.rdata = 32'h0000_0000;
					endcase
				end
			end
			BUS_ACK: begin
				s_nxt.bus = BUS_IDLE;
				s_nxt.waitreq = 1'b1;
			end
			default: begin
				s_nxt.bus = BUS_IDLE;
				s_nxt.waitreq = 1'b1;
			end
		endcase

		if (wr_ok && hit == REG_ISTAT) begin
			s_nxt.istat = s_r.istat & ~avs_writedata_i[3:0];
		end
		if (wr_ok && hit == REG_IMASK) begin
			s_nxt.imask = avs_writedata_i[3:0];
		end

		for (int c = 0; c < 2; c++) begin
			// Byte write only; single-bit access arrives as a byte write
			if (wr_ok && hit == (c == 0 ? REG_CH1 : REG_CH2)) begin
				s_nxt.tsel[c][`DTS_FIX1_BIT] = avs_writedata_i[`DTS_FIX1_BIT];
				s_nxt.tsel[c][`DTS_SRC_MSB:`DTS_SRC_LSB] = avs_writedata_i[`DTS_SRC_MSB:`DTS_SRC_LSB];
				if (!avs_writedata_i[`DTS_PEND_BIT]) begin
					s_nxt.tsel[c][`DTS_PEND_BIT] = 1'b0;
				end
				if (!avs_writedata_i[`DTS_OVF_BIT]) begin
					s_nxt.tsel[c][`DTS_OVF_BIT] = 1'b0;
				end
			end
			if (service_i[c]) begin
				s_nxt.tsel[c][`DTS_PEND_BIT] = 1'b0;
			end
			// Hardware set last so it beats any clear in the same cycle
			if (trig[c]) begin
				if (s_r.tsel[c][`DTS_PEND_BIT] && !service_i[c]) begin
					s_nxt.tsel[c][`DTS_OVF_BIT] = 1'b1;
					s_nxt.istat[`DTS_IS_OVF_LSB + c] = 1'b1;
				end
				s_nxt.tsel[c][`DTS_PEND_BIT] = 1'b1;
				s_nxt.istat[`DTS_IS_TRIG_LSB + c] = 1'b1;
			end
		end

		s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
	end

	// ==============================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_r.bus <= BUS_IDLE;
			s_r.waitreq <= 1'b1;
			s_r.rdata <= 32'h0000_0000;
			s_r.tsel[0] <= `DTS_TSEL_RST;
			s_r.tsel[1] <= `DTS_TSEL_RST;
			s_r.istat <= `DTS_IREG_RST;
			s_r.imask <= `DTS_IREG_RST;
			s_r.irq <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata_o = s_r.rdata;
	assign avs_waitrequest_o = s_r.waitreq;
	assign irq_o = s_r.irq;
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			dma_req_o[c] = s_r.tsel[c][`DTS_PEND_BIT];
		end
	end

	// ==============================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_req_idle;
		s_r.bus == BUS_IDLE && (avs_read_i || avs_write_i);
	endsequence

	sequence s_one_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	a_bus_one_wait: assert property (s_req_idle |=> s_one_answer)
		else $error("bus answer not one cycle after request");

	a_reset_zero: assert property ($fell(reset_i) |-> s_r.tsel[0] == 8'h00 && s_r.tsel[1] == 8'h00)
		else $error("trigger registers not zero after reset");

	generate
		for (gc = 0; gc < 2; gc++) begin : g_chk
			a_trig_sets_pend: assert property (trig[gc] |=> dma_req_o[gc] && s_r.istat[gc])
				else $error("trigger did not set pending");
			a_unsel_quiet: assert property (!src_vec[gc][s_r.tsel[gc][2:0]] |-> !trig[gc])
				else $error("unselected request started channel");
			a_standby_block: assert property (standby_i |-> !trig[gc])
				else $error("request in standby started channel");
			a_ovf_on_retrig: assert property (trig[gc] && dma_req_o[gc] && !service_i[gc]
				|=> s_r.tsel[gc][6] && s_r.istat[2 + gc])
				else $error("retrigger while pending did not set overflow");
			a_flag_hw_set: assert property ($rose(s_r.tsel[gc][7]) || $rose(s_r.tsel[gc][6])
				|-> $past(trig[gc]))
				else $error("flag set without hardware trigger");
			a_sw_clear: assert property (wr_ok && hit == (gc == 0 ? REG_CH1 : REG_CH2)
				&& !avs_writedata_i[7] && !trig[gc] |=> !dma_req_o[gc])
				else $error("write of zero did not clear pending");
			a_service_clear: assert property (service_i[gc] && !trig[gc] |=> !dma_req_o[gc])
				else $error("service did not clear pending");
			a_ovf_sticky: assert property (s_r.tsel[gc][6] && !wr_ok |=> s_r.tsel[gc][6])
				else $error("overflow flag dropped without software clear");
		end
	endgenerate

	// ==============================================================
	// Bus answer checks
	// Idle bus must keep the master stalled, or a stray answer would
	// complete a request that was never taken
	a_wait_when_idle: assert property (s_r.bus == BUS_IDLE && !(avs_read_i || avs_write_i)
		|=> avs_waitrequest_o)
		else $error("waitrequest dropped without a request");

	a_rdata_upper: assert property (avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	a_read_ch1: assert property (s_req_idle and (avs_read_i && hit == REG_CH1) |=>
		avs_readdata_o[7:0] == $past(s_r.tsel[0]))
		else $error("channel 1 read data wrong");

	a_read_ch2: assert property (s_req_idle and (avs_read_i && hit == REG_CH2) |=>
		avs_readdata_o[7:0] == $past(s_r.tsel[1]))
		else $error("channel 2 read data wrong");

	a_unmapped_write: assert property (wr_ok && hit == REG_NONE
		|=> $stable(s_r.imask))
		else $error("unmapped write changed the mask");

	// ==============================================================
	// Interrupt checks
	a_irq_level: assert property (irq_o == |(s_r.istat & s_r.imask))
		else $error("interrupt output does not follow status and mask");

	a_mask_write: assert property (wr_ok && hit == REG_IMASK
		|=> s_r.imask == $past(avs_writedata_i[3:0]))
		else $error("mask write did not land");

	a_istat_w1c: assert property (wr_ok && hit == REG_ISTAT && avs_writedata_i[0] && !trig[0]
		|=> !s_r.istat[`DTS_IS_TRIG_LSB])
		else $error("status write of one did not clear");

	// ==============================================================
	// Per-channel register checks
	generate
		for (gc = 0; gc < 2; gc++) begin : g_chk2
			a_pend_mirror: assert property (dma_req_o[gc] == s_r.tsel[gc][`DTS_PEND_BIT])
				else $error("pending output differs from register bit");
			a_fixed_zero: assert property (s_r.tsel[gc][4:3] == 2'h0)
				else $error("fixed zero bits set");
			a_src_write: assert property (wr_ok && hit == (gc == 0 ? REG_CH1 : REG_CH2)
				|=> s_r.tsel[gc][`DTS_SRC_MSB:`DTS_SRC_LSB] == $past(avs_writedata_i[2:0]))
				else $error("source field write did not land");
			// Lane 0 disabled must leave the configuration alone
			a_lane_off: assert property (s_r.bus == BUS_ACK && avs_write_i && !avs_byteenable_i[0]
				|=> $stable(s_r.tsel[gc][`DTS_SRC_MSB:`DTS_SRC_LSB]))
				else $error("write with lane 0 off changed source field");
			a_one_no_set: assert property (wr_ok && hit == (gc == 0 ? REG_CH1 : REG_CH2)
				&& avs_writedata_i[7] && !dma_req_o[gc] && !trig[gc] |=> !dma_req_o[gc])
				else $error("software write of one set pending");
			a_ovf_no_set: assert property (wr_ok && hit == (gc == 0 ? REG_CH1 : REG_CH2)
				&& avs_writedata_i[6] && !s_r.tsel[gc][6] && !trig[gc] |=> !s_r.tsel[gc][6])
				else $error("software write of one set overflow");
			// Service in the retrigger cycle hands the new request straight on
			a_serv_retrig: assert property (service_i[gc] && trig[gc] && !s_r.tsel[gc][6] && !wr_ok
				|=> dma_req_o[gc] && !s_r.tsel[gc][6])
				else $error("service with trigger gave wrong flags");
			a_idle_no_pend: assert property (!trig[gc] && !dma_req_o[gc] |=> !dma_req_o[gc])
				else $error("pending set without a trigger");
		end
	endgenerate

endmodule // dts_top

// ---- bench/dts_src_model.sv ----
`timescale 1ns/1ps
// ==========
// Peripheral request lines, low between pulses
module dts_src_model
	import dts_pkg::*;
(
	input wire logic fire_i,       // Raise one request
	input wire logic ch_i,         // Use channel 2 table
	input wire logic [2:0] code_i, // Source code
	output dts_irq_s irq_o         // Request lines
);
	// Bit of the request struct for each source code
	localparam logic [3:0] T1 [8] = '{4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h4, 4'h3, 4'h0};
	localparam logic [3:0] T2 [8] = '{4'hB, 4'hA, 4'h9, 4'h6, 4'h5, 4'h4, 4'h2, 4'h1};
	logic [11:0] v;
	always_comb begin
		v = 12'h000;
		if (fire_i) begin
			v[ch_i ? T2[code_i] : T1[code_i]] = 1'h1;
		end
		irq_o = v;
	end
endmodule // dts_src_model

// ---- bench/dma_trigger_source_select_tb.sv ----
`timescale 1ns/1ps
`include "dts_defines.svh"
module dma_trigger_source_select_tb
	import dts_pkg::*;
;
	typedef struct packed {logic ch; logic [2:0] sel; logic [2:0] fire; logic exp;} dts_row_s;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic rd = 1'h0, wr = 1'h0, standby = 1'h0, fire = 1'h0, fch = 1'h0, waitreq, irq;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
	logic [3:0] be = 4'hF;
	logic [1:0] service = 2'h0, dma_req;
	logic [2:0] fcode = 3'h0;
	logic [7:0] q;
	dts_irq_s src;
	dts_row_s rows [32];
	dts_row_s r;
	int miscompares = 0, n_checks = 0, cyc = 0;
	always #5 clk_i = ~clk_i;
	// ==========
	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	dts_top dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.irq_src_i(src), .standby_i(standby), .service_i(service), .dma_req_o(dma_req), .irq_o(irq));
	dts_src_model src_m (.fire_i(fire), .ch_i(fch), .code_i(fcode), .irq_o(src));
	// ==========
	// Tasks
	function automatic logic [31:0] ca(input logic c);
		return c ? `DTS_CH2_IDX : `DTS_CH1_IDX;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		@(posedge clk_i);
		while (waitreq !== 1'h0) @(posedge clk_i);
		q = rdata[7:0];
		wr <= 1'h0;
		rd <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk(nm, {24'h0, e}, {24'h0, q});
	endtask
	task automatic pulse(input logic c, input logic [2:0] k);
		fch <= c;
		fcode <= k;
		fire <= 1'h1;
		@(posedge clk_i);
		fire <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'h0;
		@(posedge clk_i);
		rdc("ch1 reset", `DTS_CH1_IDX, 8'h00);
		rdc("ch2 reset", `DTS_CH2_IDX, 8'h00);
		rdc("unmapped", 32'h0, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 32; i++) rows[i] = '{i[4], i[2:0], i[3] ? i[2:0] + 3'h3 : i[2:0], !i[3]};
		foreach (rows[i]) begin
			r = rows[i];
			// Channel sequencer is held idle here, so reprogramming is allowed
			bus(1'h1, ca(r.ch), 8'h20 | {5'h0, r.sel});
			pulse(r.ch, r.fire);
			chk("dma_req", {31'h0, r.exp}, {31'h0, dma_req[r.ch]});
			rdc("trigger reg", ca(r.ch), {r.exp, 7'h20 | {4'h0, r.sel}});
		end
		$display("test sources done");
		bus(1'h1, `DTS_CH1_IDX, 8'h25);
		pulse(1'h0, 3'h5);
		pulse(1'h0, 3'h5);
		rdc("overflow", `DTS_CH1_IDX, 8'hE5);
		bus(1'h1, `DTS_CH1_IDX, 8'hE5);
		rdc("write one", `DTS_CH1_IDX, 8'hE5);
		be <= 4'hE;
		bus(1'h1, `DTS_CH1_IDX, 8'h20);
		be <= 4'hF;
		rdc("lane off", `DTS_CH1_IDX, 8'hE5);
		bus(1'h1, `DTS_CH1_IDX, 8'h25);
		rdc("cleared", `DTS_CH1_IDX, 8'h25);
		$display("test flags done");
		pulse(1'h0, 3'h5);
		service <= 2'h1;
		@(posedge clk_i);
		service <= 2'h0;
		@(posedge clk_i);
		chk("serviced", 32'h0, {31'h0, dma_req[0]});
		standby <= 1'h1;
		pulse(1'h0, 3'h5);
		standby <= 1'h0;
		chk("standby", 32'h0, {31'h0, dma_req[0]});
		$display("test service done");
		bus(1'h1, `DTS_ISTAT_IDX, 8'h0F);
		bus(1'h1, `DTS_IMASK_IDX, 8'h01);
		pulse(1'h1, 3'h7);
		@(posedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq});
		pulse(1'h0, 3'h5);
		@(posedge clk_i);
		chk("irq set", 32'h1, {31'h0, irq});
		bus(1'h1, `DTS_ISTAT_IDX, 8'h01);
		rdc("status", `DTS_ISTAT_IDX, 8'h02);
		chk("irq clear", 32'h0, {31'h0, irq});
		$display("test irq done");
		end_of_test();
	end
endmodule // dma_trigger_source_select_tb
